// >>> verilog/shr_pkg.sv
// package for the serial handshake router: register map, fields, carriers
// assumes an apb slave with 32-bit data and word-aligned registers
package shr_pkg;
	localparam logic [7:0] ctrl_addr = 8'h00;
	localparam logic [7:0] stat_addr = 8'h04;
	localparam logic [7:0] map_addr = 8'h08;
	// control field positions
	localparam int term_bit = 0;
	localparam int modem_bit = 1;
	localparam int monitor_bit = 2;
	localparam int tty_bit = 3;
	localparam int echo_bit = 4;
	localparam int remote_bit = 5;
	localparam int bypass_bit = 6;
	localparam int swreq_bit = 7;
	localparam logic [31:0] ctrl_reset = 32'h0000_0041;
	// default command codes, one per strobe (arbitrary, software may rewrite all but bits 34:31 of the last code)
	localparam logic [34:0] map_reset = {5'h07, 5'h06, 5'h05, 5'h04, 5'h03, 5'h02, 5'h01};
	localparam int cmd_count = 7;

	// pins from the terminal, modem and teletype
	typedef struct packed {
		logic term_ready;
		logic term_send_req;
		logic term_data;
		logic modem_clear_in;
		logic modem_data;
		logic tty_data;
	} shr_line_in_t;

	// pins toward the terminal, modem and teletype
	typedef struct packed {
		logic terminal_set_ready_out;
		logic terminal_clear_out;
		logic term_rx_line;
		logic modem_ready_out;
		logic modem_send_req;
		logic modem_tx_line;
		logic tty_out;
	} shr_line_out_t;

	// active-low command strobes
	typedef struct packed {
		logic cmd_drive_left_n;
		logic cmd_drive_right_n;
		logic cmd_backspace_n;
		logic cmd_punch_stop_n;
		logic cmd_reader_stop_n;
		logic cmd_punch_start_n;
		logic cmd_reader_start_n;
	} shr_cmd_t;
endpackage : shr_pkg

// >>> verilog/shr_router.sv
// handshake, serial steering and received-command decoding for a tape interface
// assumes all inputs synchronous to pclk; reader/punch clocks arrive as enables
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module shr_router (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic reader_clk_tick,
	input wire logic punch_clk_tick,
	input wire logic interface_ready,
	input wire logic reader_sys_ok,
	input wire logic reader_run,
	input wire logic reader_word_valid,
	input wire logic cr_hold_delay_n,
	input wire logic uart_serial_out,
	input wire logic rx_word_received,
	input wire logic [7:1] uart_rx_bits,
	input wire shr_pkg::shr_line_in_t line_in,
	output shr_pkg::shr_line_out_t line_out,
	output logic uart_serial_in,
	output logic tx_load_strobe_n,
	output logic rx_flag_clear_n,
	output shr_pkg::shr_cmd_t cmd
);

	logic [31:0] ctrl;
	logic [34:0] cmd_map;
	logic internal_send_request;
	logic load_armed;
	logic word_seen;
	logic apb_write;

	logic term_sel, modem_select, monitor_sel, tty_sel, echo_sel, remote_sel;
	logic modem_or_monitor_sel, internal_set_ready_n, word_pending, internal_clear_to_send;
	logic set_send_request_n, selected_serial_in_n, modem_tx_line, load_ok;

	function automatic logic map_hit(input logic [34:0] m, input int i, input logic [4:0] c);
		map_hit = (m[i*5 +: 5] == c);
	endfunction : map_hit

	////////////////////////////////////////////////////////////////////////
	// combinational handshake and selection terms
	assign term_sel = ctrl[shr_pkg::term_bit];
	assign modem_select = ctrl[shr_pkg::modem_bit];
	assign monitor_sel = ctrl[shr_pkg::monitor_bit];
	assign tty_sel = ctrl[shr_pkg::tty_bit];
	assign echo_sel = ctrl[shr_pkg::echo_bit];
	assign remote_sel = ctrl[shr_pkg::remote_bit];
	assign modem_or_monitor_sel = modem_select | monitor_sel;
	assign internal_set_ready_n = ~(line_in.term_ready & term_sel);
	assign word_pending = reader_run & reader_word_valid;
	// open bypass switch (bit low) stands in for a missing modem clear
	assign internal_clear_to_send = modem_or_monitor_sel
		& (line_in.modem_clear_in | ~ctrl[shr_pkg::bypass_bit]);
	assign set_send_request_n = ~(word_pending
		& (~line_in.modem_clear_in | ctrl[shr_pkg::swreq_bit]));
	assign load_ok = ~internal_set_ready_n & reader_sys_ok
		& internal_clear_to_send & internal_send_request;
	// transmitter, or terminal data in monitor mode, feeds the modem path
	assign modem_tx_line = monitor_sel ? line_in.term_data
		: (uart_serial_out & (modem_select | (monitor_sel & reader_run)));
	always_comb begin
		selected_serial_in_n = 1'b1;
		if (term_sel)
			selected_serial_in_n = ~line_in.term_data;
		else if (modem_or_monitor_sel)
			selected_serial_in_n = ~line_in.modem_data;
		else if (tty_sel)
			selected_serial_in_n = ~line_in.tty_data;
	end

	////////////////////////////////////////////////////////////////////////
	// apb slave: zero wait states, unmapped reads zero with pslverr
	assign apb_write = psel & penable & pwrite;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= shr_pkg::ctrl_reset;
			cmd_map <= shr_pkg::map_reset;
		end else if (clk_en && apb_write) begin
			if (paddr == shr_pkg::ctrl_addr)
				ctrl <= {24'h000000, pwdata[7:0]};
			if (paddr == shr_pkg::map_addr)
				cmd_map <= pwdata[30:0] == 31'h0 ? cmd_map : {cmd_map[34:31], pwdata[30:0]};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else if (clk_en) begin
			pready <= psel & ~penable;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
			if (psel && !penable) begin
				unique case (paddr)
					shr_pkg::ctrl_addr: prdata <= ctrl;
					shr_pkg::stat_addr: prdata <= {26'h0000000, rx_word_received,
						word_pending, internal_clear_to_send, internal_send_request,
						~internal_set_ready_n, ~tx_load_strobe_n};
					shr_pkg::map_addr: prdata <= {1'b0, cmd_map[30:0]};
					default: pslverr <= 1'b1;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// request latch toward the modem
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			internal_send_request <= 1'b0;
		else if (clk_en) begin
			if (!set_send_request_n)
				internal_send_request <= 1'b1;
			else if (!reader_run)
				internal_send_request <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// two-flop load strobe on reader clock ticks
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			load_armed <= 1'b0;
			tx_load_strobe_n <= 1'b1;
		end else if (clk_en && reader_clk_tick) begin
			if (!load_armed && word_pending && cr_hold_delay_n && tx_load_strobe_n) begin
				load_armed <= 1'b1;
				tx_load_strobe_n <= 1'b0;
			end else if (load_armed && load_ok) begin
				load_armed <= 1'b0;
				tx_load_strobe_n <= 1'b1;
			end else if (!word_pending)
				load_armed <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// receiver flag clear on punch clock tick
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_flag_clear_n <= 1'b1;
			word_seen <= 1'b0;
		end else if (clk_en) begin
			if (rx_word_received)
				word_seen <= 1'b1;
			if (punch_clk_tick) begin
				rx_flag_clear_n <= ~(word_seen | rx_word_received);
				if (word_seen | rx_word_received)
					word_seen <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// command decode
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			cmd <= 7'h7f;
		else if (clk_en) begin
			for (int i = 0; i < shr_pkg::cmd_count; i++) begin
				cmd[i] <= ~(remote_sel & rx_word_received & (uart_rx_bits[7:6] == 2'h0)
					& map_hit(cmd_map, i, uart_rx_bits[5:1]));
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// registered line drivers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			line_out <= 7'h00;
			uart_serial_in <= 1'b1;
		end else if (clk_en) begin
			uart_serial_in <= ~selected_serial_in_n;
			line_out.terminal_set_ready_out <= interface_ready & term_sel;
			line_out.terminal_clear_out <= monitor_sel ? line_in.modem_clear_in
				: line_in.term_send_req & line_out.terminal_set_ready_out;
			line_out.modem_ready_out <= monitor_sel ? line_in.term_ready
				: interface_ready & modem_select;
			line_out.modem_send_req <= monitor_sel ? line_in.term_send_req
				: internal_send_request;
			if (echo_sel) begin
				line_out.modem_tx_line <= line_in.modem_data;
				line_out.term_rx_line <= line_in.term_data;
				line_out.tty_out <= line_in.tty_data;
			end else begin
				line_out.modem_tx_line <= modem_tx_line;
				line_out.term_rx_line <= (uart_serial_out & term_sel)
					| (line_in.modem_data & modem_or_monitor_sel);
				line_out.tty_out <= uart_serial_out;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	set_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en |=> line_out.terminal_set_ready_out == $past(interface_ready & term_sel))
		else $error("terminal set-ready wrong");
	modem_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && !monitor_sel |=> line_out.modem_ready_out == $past(interface_ready & modem_select))
		else $error("modem ready wrong");
	strobe_pair_a: assert property (@(posedge pclk) disable iff (!presetn)
		$fell(tx_load_strobe_n) |-> load_armed)
		else $error("strobe low without arming");
	strobe_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(tx_load_strobe_n) |-> $past(load_ok))
		else $error("strobe released without load conditions");
	strobe_enable_a: assert property (@(posedge pclk) disable iff (!presetn)
		$fell(tx_load_strobe_n) |-> $past(word_pending & cr_hold_delay_n))
		else $error("load without pending word");
	send_req_a: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && !set_send_request_n |=> internal_send_request)
		else $error("request latch not set");
	decode_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && !remote_sel |=> cmd == 7'h7f)
		else $error("command decoded outside remote");
	flag_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
		$fell(rx_flag_clear_n) |-> $past(punch_clk_tick))
		else $error("flag clear off punch clock");
	echo_loop_a: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && echo_sel |=> line_out.tty_out == $past(line_in.tty_data))
		else $error("teletype echo broken");
	echo_modem_a: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && echo_sel |=> line_out.modem_tx_line == $past(line_in.modem_data))
		else $error("modem echo broken");
	echo_term_a: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && echo_sel |=> line_out.term_rx_line == $past(line_in.term_data))
		else $error("terminal echo broken");

	////////////////////////////////////////////////////////////////////////
	// handshake checks, terminal and modem sides
	term_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && !monitor_sel |=> line_out.terminal_clear_out
		== $past(line_in.term_send_req & line_out.terminal_set_ready_out))
		else $error("terminal clear wrong");
	modem_req_a: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && !monitor_sel |=> line_out.modem_send_req == $past(internal_send_request))
		else $error("modem request wrong");
	mon_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && monitor_sel |=> line_out.modem_ready_out == $past(line_in.term_ready))
		else $error("monitor ready pass-through wrong");
	mon_req_a: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && monitor_sel |=> line_out.modem_send_req == $past(line_in.term_send_req))
		else $error("monitor request pass-through wrong");
	mon_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && monitor_sel |=> line_out.terminal_clear_out == $past(line_in.modem_clear_in))
		else $error("monitor clear pass-through wrong");
	mon_data_a: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && monitor_sel && !echo_sel |=> line_out.modem_tx_line == $past(line_in.term_data))
		else $error("monitor data pass-through wrong");

	////////////////////////////////////////////////////////////////////////
	// serial steering checks; selection terms rebuilt from the control bits
	modem_tx_a: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && !echo_sel && modem_select && !monitor_sel
		|=> line_out.modem_tx_line == $past(uart_serial_out))
		else $error("transmitter not on modem line");
	tty_tx_a: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && !echo_sel |=> line_out.tty_out == $past(uart_serial_out))
		else $error("transmitter not on teletype line");
	term_tx_a: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && !echo_sel && term_sel && !modem_select && !monitor_sel
		|=> line_out.term_rx_line == $past(uart_serial_out))
		else $error("transmitter not on terminal line");
	term_fwd_a: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && !echo_sel && !term_sel && (modem_select || monitor_sel)
		|=> line_out.term_rx_line == $past(line_in.modem_data))
		else $error("modem data not forwarded to terminal");
	rx_term_a: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && term_sel |=> uart_serial_in == $past(line_in.term_data))
		else $error("receiver not fed from terminal");
	rx_modem_a: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && !term_sel && (modem_select || monitor_sel)
		|=> uart_serial_in == $past(line_in.modem_data))
		else $error("receiver not fed from modem");
	rx_tty_a: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && tty_sel && !term_sel && !modem_select && !monitor_sel
		|=> uart_serial_in == $past(line_in.tty_data))
		else $error("receiver not fed from teletype");

	////////////////////////////////////////////////////////////////////////
	// decode, strobe, flag and bus checks
	decode_word_a: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && !rx_word_received |=> cmd == 7'h7f)
		else $error("command decoded without a word");
	decode_high_a: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && uart_rx_bits[7:6] != 2'h0 |=> cmd == 7'h7f)
		else $error("command decoded with high bits set");
	decode_hit_a: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && remote_sel && rx_word_received && uart_rx_bits[7:6] == 2'h0
		&& cmd_map[4:0] == uart_rx_bits[5:1] |=> !cmd.cmd_reader_start_n)
		else $error("start reader code missed");
	strobe_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && !tx_load_strobe_n && !reader_clk_tick |=> !tx_load_strobe_n)
		else $error("strobe released off reader clock");
	flag_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && punch_clk_tick && rx_word_received |=> !rx_flag_clear_n)
		else $error("flag clear not pulsed");
	freeze_a: assert property (@(posedge pclk) disable iff (!presetn)
		!clk_en |=> $stable(line_out) && $stable(cmd) && $stable(tx_load_strobe_n))
		else $error("state moved while clock enable low");
	apb_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && psel && !penable |=> pready)
		else $error("no ready in access cycle");
	apb_err_a: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && psel && !penable && paddr != shr_pkg::ctrl_addr
		&& paddr != shr_pkg::stat_addr && paddr != shr_pkg::map_addr |=> pslverr)
		else $error("unmapped access not refused");

endmodule : shr_router

// >>> test/shr_far_end.sv
// far-side model: terminal, modem and teletype behind the router's line pins
// assumes the bench drives the model's levels by non-blocking assignment
`timescale 1ns/1ps
module shr_far_end (
	input wire shr_pkg::shr_line_out_t line_out,
	input wire logic term_ready,
	input wire logic term_send_req,
	input wire logic modem_clear,
	input wire logic data_bit,
	output shr_pkg::shr_line_in_t line_in
);
	// terminal and modem serial lines rest at mark until the far side may talk; teletype data always follows data_bit
	always_comb begin
		line_in.term_ready = term_ready;
		line_in.term_send_req = term_send_req;
		line_in.term_data = line_out.terminal_clear_out ? data_bit : 1'b1;
		line_in.modem_clear_in = modem_clear;
		line_in.modem_data = line_out.modem_ready_out ? ~data_bit : 1'b1;
		line_in.tty_data = data_bit;
	end
endmodule : shr_far_end

// >>> test/testbench.sv
// self-checking bench for the serial handshake router, registers over apb
// assumes the far-end model supplies the line inputs
`timescale 1ns/1ps
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin errors++; \
	$display("Error %s expected %h seen %h", n, e, a); end end
module testbench;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic rtick, ptick, ifr, rsok, rrun, rvalid, cr_n, txo, rxw;
	logic tready, treq, mclr, dbit, rxin, ld_n, fc_n;
	logic [7:1] rxb;
	shr_pkg::shr_line_in_t li;
	shr_pkg::shr_line_out_t lo;
	shr_pkg::shr_cmd_t cmd;
	int errors, checked;
	shr_router u_shr_router (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .reader_clk_tick(rtick), .punch_clk_tick(ptick),
		.interface_ready(ifr), .reader_sys_ok(rsok), .reader_run(rrun),
		.reader_word_valid(rvalid), .cr_hold_delay_n(cr_n), .uart_serial_out(txo),
		.rx_word_received(rxw), .uart_rx_bits(rxb), .line_in(li), .line_out(lo),
		.uart_serial_in(rxin), .tx_load_strobe_n(ld_n), .rx_flag_clear_n(fc_n), .cmd(cmd));
	shr_far_end u_shr_far_end (.line_out(lo), .term_ready(tready), .term_send_req(treq),
		.modem_clear(mclr), .data_bit(dbit), .line_in(li));
	////////////////////////////////////////
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	task automatic print_verdict();
		if (errors == 0 && checked > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : print_verdict
	task automatic wt(input int n);
		repeat (n) @(posedge pclk);
	endtask : wt
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 16) begin
			errors++;
			print_verdict();
		end
	endtask : apb
	task automatic cfg(input logic [31:0] v);
		apb(shr_pkg::ctrl_addr, 1'b1, v);
		wt(3);
	endtask : cfg
	task automatic stat();
		wt(3);
		apb(shr_pkg::stat_addr, 1'b0, 32'h0);
	endtask : stat
	task automatic rclk();
		@(posedge pclk);
		rtick <= 1'b1;
		@(posedge pclk);
		rtick <= 1'b0;
		wt(2);
	endtask : rclk
	////////////////////////////////////////
	initial begin
		errors = 0;
		checked = 0;
		{presetn, psel, penable, pwrite, rtick, ptick, ifr, rsok, rrun, rvalid} = '0;
		{txo, rxw, tready, treq, mclr, dbit} = '0;
		cr_n = 1'b1;
		paddr = 8'h00;
		pwdata = 32'h0;
		rxb = 7'h00;
		wt(20);
		`CHK("cmd", 7'h7f, cmd)
		presetn <= 1'b1;
		apb(shr_pkg::ctrl_addr, 1'b0, 32'h0);
		`CHK("ctrl", shr_pkg::ctrl_reset, rd)
		apb(8'h0c, 1'b0, 32'h0);
		`CHK("slverr", 1'b1, err)
		ifr <= 1'b1;
		tready <= 1'b1;
		treq <= 1'b1;
		stat();
		`CHK("set_ready_out", 1'b1, lo.terminal_set_ready_out)
		`CHK("clear_out", 1'b1, lo.terminal_clear_out)
		`CHK("set_ready", 1'b1, rd[1])
		for (int b = 0; b < 2; b++) begin
			txo <= b[0];
			dbit <= b[0];
			wt(4);
			`CHK("rx_in", b[0], rxin)
			`CHK("term_rx", b[0], lo.term_rx_line)
			`CHK("tty_out", b[0], lo.tty_out)
		end
		tready <= 1'b0;
		stat();
		`CHK("set_ready", 1'b0, rd[1])
		tready <= 1'b1;
		for (int i = 0; i < 3; i++) begin
			cfg(32'h1 << i);
			stat();
			`CHK("int_clear", i != 0, rd[3])
			`CHK("modem_ready", i != 0, lo.modem_ready_out)
		end
		`CHK("modem_tx", 1'b1, lo.modem_tx_line)
		`CHK("rx_in", 1'b0, rxin)
		`CHK("term_rx", 1'b0, lo.term_rx_line)
		cfg(32'h42);
		stat();
		`CHK("int_clear", 1'b0, rd[3])
		cfg(32'h43);
		rsok <= 1'b1;
		cr_n <= 1'b0;
		rrun <= 1'b1;
		rvalid <= 1'b1;
		stat();
		`CHK("pending", 1'b1, rd[4])
		`CHK("req_latch", 1'b1, rd[2])
		`CHK("modem_req", 1'b1, lo.modem_send_req)
		rclk();
		`CHK("load_n", 1'b1, ld_n)
		cr_n <= 1'b1;
		rclk();
		`CHK("load_n", 1'b0, ld_n)
		rclk();
		`CHK("load_n", 1'b0, ld_n)
		mclr <= 1'b1;
		wt(3);
		rclk();
		`CHK("load_n", 1'b1, ld_n)
		rrun <= 1'b0;
		rvalid <= 1'b0;
		cfg(32'h44);
		for (int b = 0; b < 2; b++) begin
			treq <= b[0];
			wt(4);
			`CHK("modem_req", b[0], lo.modem_send_req)
		end
		cfg(32'h12);
		for (int b = 0; b < 2; b++) begin
			dbit <= b[0];
			txo <= ~b[0];
			wt(4);
			`CHK("modem_tx", ~b[0], lo.modem_tx_line)
			`CHK("tty_out", b[0], lo.tty_out)
			`CHK("rx_in", ~b[0], rxin)
		end
		cfg(32'h61);
		rxw <= 1'b1;
		for (int i = 0; i < 7; i++) begin
			rxb <= {2'b00, 5'(i + 1)};
			wt(4);
			`CHK("cmd", 7'h7f ^ (7'h01 << i), cmd)
		end
		rxb <= 7'h21;
		wt(4);
		`CHK("cmd", 7'h7f, cmd)
		apb(shr_pkg::map_addr, 1'b1, {1'b0, shr_pkg::map_reset[30:5], 5'h1f});
		rxb <= 7'h1f;
		wt(4);
		`CHK("cmd", 7'h7e, cmd)
		rxb <= 7'h01;
		wt(4);
		`CHK("cmd", 7'h7f, cmd)
		cfg(32'h41);
		`CHK("cmd", 7'h7f, cmd)
		`CHK("flag_clr", 1'b1, fc_n)
		@(posedge pclk);
		ptick <= 1'b1;
		@(posedge pclk);
		ptick <= 1'b0;
		wt(2);
		`CHK("flag_clr", 1'b0, fc_n)
		print_verdict();
	end
endmodule : testbench
